// ===== design/dat_pkg.sv
/*
 Shared constants and types of the detector acquisition timing block.
 Assumes a 50 MHz MCLK; all derived rates are clock-enable based.
*/
package dat_pkg;
    localparam int CLK_MHZ = 50;
    localparam int MAIN_MHZ = 24;
    localparam int CLK_HZ = CLK_MHZ * 1000000;
    localparam logic [5:0] NCO_INC = 6'(MAIN_MHZ);
    localparam logic [5:0] NCO_MOD = 6'(CLK_MHZ);
    localparam int CPU_MHZ = 12;
    localparam int DAC_MHZ = 6;
    localparam int IF_MHZ = 3;
    localparam int INTEG_HZ = 1200;
    localparam int INTEG_HALF_TICKS = MAIN_MHZ * 1000000 / INTEG_HZ / 2;
    localparam int CONV_TIME_US = 25000;
    localparam int CONV_PERIODS = CONV_TIME_US * INTEG_HZ / 1000000;
    localparam int POR_TIME_MS = 100;
    localparam int POR_CYCLES = POR_TIME_MS * (CLK_HZ / 1000);
    localparam logic [15:0] ROM_BASE = 16'h0000;
    localparam logic [15:0] ROM_MASK = 16'h8000;
    localparam logic [15:0] SRAM_BASE = 16'h8000;
    localparam logic [15:0] SRAM_MASK = 16'hE000;
    localparam logic [15:0] EEP_BASE = 16'hA000;
    localparam logic [15:0] EEP_MASK = 16'hF800;
    localparam logic [15:0] PER_BASE = 16'hC000;
    localparam logic [15:0] PER_MASK = 16'hFFF0;
    localparam logic [3:0] OFS_GAIN = 4'h0;
    localparam logic [3:0] OFS_GRAT = 4'h1;
    localparam logic [3:0] OFS_FILT = 4'h2;
    localparam logic [3:0] OFS_BUZZ = 4'h3;
    localparam logic [3:0] OFS_RESP = 4'h4;
    localparam logic [3:0] OFS_ABS_LO = 4'h5;
    localparam logic [3:0] OFS_ABS_HI = 4'h6;
    localparam logic [3:0] OFS_STAT = 4'h7;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [2:0] RESP_RESET = 3'h2;
    localparam logic [7:0] LOG10_2_Q8 = 8'h4D;
    typedef enum logic [2:0] {
        PH_ZERO = 3'b001,
        PH_SAMPLE = 3'b010,
        PH_REF = 3'b100
    } dat_phase_e;
    typedef struct packed {
        logic [1:0] refr;
        logic [1:0] sample_channel;
    } dat_gain_s;
endpackage

// ===== design/dat_timing.sv
/*
 Clock division, reset generation, multiplexed bus decode and measurement
 sequencing of the detector controller board.
 Assumes all pins synchronous to MCLK and an external PWM modulator
 whose comparator feeds COMP_IN.
*/
// Functional notes
// [RULE1] 12 MHz CPU, 3 MHz interface clocks
// [RULE2] Counter at 24 MHz, 1.2 kHz integration
// [RULE3] 6 MHz converter output pulse clock
// [RULE4] Hold reset about 100 ms after power
// [RULE5] Reset while supply below 4.7 V
// [RULE6] Multiplexed 8-bit bus, address latched first
// [RULE7] Decode 32K ROM, 8K RAM, 2K EEPROM
// [RULE8] EEPROM keeps programs, calibrations and settings
// [RULE9] Processor picks one of four gains
// [RULE10] 18-bit result every 25 ms
// [RULE11] Cycle zero, sample, reference forever
// [RULE12] Zero calibration from grounded input reading
// [RULE13] Filter by response, absorbance from logs
// [RULE14] Motor phase patterns written by processor
// [RULE15] Processor drives buzzer and filter motor
// [RULE16] Feedback pulse-width modulation conversion
// [RULE17] Count main-clock pulses of pulse width
// [RULE18] Subtract zero before absorbance calculation
`timescale 1ns/1ps
`default_nettype none
module dat_timing
    import dat_pkg::*;
#(
    parameter int POR_CYC = POR_CYCLES,
    parameter int INTEG_HALF = INTEG_HALF_TICKS
) (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic SUPPLY_LOW,
    input wire logic COMP_IN,
    input wire logic ALE,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic [7:0] ADDR_HI,
    input wire logic [7:0] AD_IN,
    output logic [7:0] AD_OUT,
    output logic AD_OE,
    output logic ROM_CS_N,
    output logic SRAM_CS_N,
    output logic EEPROM_CS_N,
    output logic SYS_RESET_N,
    output logic ADC_TICK,
    output logic CPU_CLK,
    output logic DAC_CLK,
    output logic IF_CLK,
    output logic INTEG_CLK,
    output logic PWM_REF_SEL,
    output logic [2:0] MUX_SEL,
    output dat_gain_s GAIN,
    output logic [3:0] GRATING_PHASE,
    output logic [3:0] FILTER_PHASE,
    output logic BUZZER,
    output logic [17:0] RAW_RESULT,
    output logic [15:0] ABSORBANCE_VALUE,
    output logic ABS_VALID
);
    function automatic logic in_region(input logic [15:0] a, input logic [15:0] base,
                                       input logic [15:0] mask);
        in_region = (a & mask) == base;
    endfunction

    // Base-two log in Q5.8; the caller guarantees a nonzero input
    function automatic logic [12:0] log2_q8(input logic [17:0] x);
        logic [4:0] p;
        logic [17:0] n;
        p = 5'd0;
        n = 18'h0_0000;
        for (int i = 0; i < 18; i++) begin
            if (x[i]) begin
                p = 5'(i);
            end
        end
        n = x << (5'd17 - p);
        log2_q8 = {p, n[16:9]};
    endfunction

    // Main 24 MHz rate as an enable; edges jitter by one MCLK period
    logic [5:0] nco_q;
    logic [6:0] nco_sum;
    logic tick_q;
    // One spare bit: the sum passes 63 before the wrap is taken
    assign nco_sum = {1'b0, nco_q} + {1'b0, NCO_INC};
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            nco_q <= 6'h00;
            tick_q <= 1'b0;
        end else if (CE) begin
            if (nco_sum >= {1'b0, NCO_MOD}) begin
                nco_q <= 6'(nco_sum - {1'b0, NCO_MOD});
                tick_q <= 1'b1;
            end else begin
                nco_q <= nco_sum[5:0];
                tick_q <= 1'b0;
            end
        end
    end
    assign ADC_TICK = tick_q & CE; // [RULE2]

    logic [2:0] div_q;
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_q <= 3'h0;
        end else if (CE && tick_q) begin
            div_q <= div_q + 3'h1; // [RULE1] [RULE3]
        end
    end
    assign CPU_CLK = div_q[0]; // [RULE1]
    assign DAC_CLK = div_q[1]; // [RULE3]
    assign IF_CLK = div_q[2]; // [RULE1]

    logic [22:0] por_cnt_q;
    logic sys_rst_n_q;
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            por_cnt_q <= 23'h00_0000;
            sys_rst_n_q <= 1'b0;
        end else if (CE) begin
            if (SUPPLY_LOW) begin
                por_cnt_q <= 23'h00_0000; // [RULE5]
                sys_rst_n_q <= 1'b0;
            end else if (por_cnt_q == 23'(POR_CYC - 1)) begin
                sys_rst_n_q <= 1'b1; // [RULE4]
            end else begin
                por_cnt_q <= por_cnt_q + 23'h00_0001;
            end
        end
    end
    // Undervoltage acts at once, without waiting for the next edge
    assign SYS_RESET_N = sys_rst_n_q & ~SUPPLY_LOW; // [RULE5]

    logic [7:0] addr_lo_q;
    logic wr_n_q;
    logic rd_n_q;
    logic [15:0] addr;
    logic per_sel;
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            addr_lo_q <= RESET_BYTE;
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
        end else if (CE) begin
            if (ALE) begin
                addr_lo_q <= AD_IN; // [RULE6]
            end
            wr_n_q <= WR_N;
            rd_n_q <= RD_N;
        end
    end
    assign addr = {ADDR_HI, addr_lo_q};
    assign per_sel = in_region(addr, PER_BASE, PER_MASK);
    assign ROM_CS_N = ~in_region(addr, ROM_BASE, ROM_MASK); // [RULE7]
    assign SRAM_CS_N = ~in_region(addr, SRAM_BASE, SRAM_MASK); // [RULE7]
    // Settings and calibrations live in this part; the block only selects it
    assign EEPROM_CS_N = ~in_region(addr, EEP_BASE, EEP_MASK); // [RULE7] [RULE8]

    logic wr_stb;
    logic rd_stb;
    assign wr_stb = CE & wr_n_q & ~WR_N & per_sel & ~ALE;
    assign rd_stb = CE & rd_n_q & ~RD_N & per_sel & ~ALE;

    dat_gain_s gain_q;
    logic [3:0] grat_q;
    logic [3:0] filt_ph_q;
    logic buzz_q;
    logic [2:0] resp_q;
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            gain_q <= '0;
            grat_q <= 4'h0;
            filt_ph_q <= 4'h0;
            buzz_q <= 1'b0;
            resp_q <= RESP_RESET;
        end else if (wr_stb) begin
            unique case (addr[3:0])
                OFS_GAIN: gain_q <= AD_IN[3:0]; // [RULE9]
                OFS_GRAT: grat_q <= AD_IN[3:0]; // [RULE14]
                OFS_FILT: filt_ph_q <= AD_IN[3:0]; // [RULE14] [RULE15]
                OFS_BUZZ: buzz_q <= AD_IN[0]; // [RULE15]
                OFS_RESP: resp_q <= AD_IN[2:0]; // [RULE13]
                default: ;
            endcase
        end
    end
    assign GAIN = gain_q;
    assign GRATING_PHASE = grat_q;
    assign FILTER_PHASE = filt_ph_q;
    assign BUZZER = buzz_q;

    // Integration period and conversion framing
    logic [13:0] half_q;
    logic integ_q;
    logic [4:0] period_q;
    logic conv_end;
    assign conv_end = CE & tick_q & (half_q == 14'(INTEG_HALF - 1)) & integ_q
                      & (period_q == 5'(CONV_PERIODS - 1));
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            half_q <= 14'h0000;
            integ_q <= 1'b0;
            period_q <= 5'h00;
        end else if (CE && tick_q) begin
            if (half_q == 14'(INTEG_HALF - 1)) begin
                half_q <= 14'h0000;
                integ_q <= ~integ_q; // [RULE2]
                if (integ_q) begin
                    period_q <= conv_end ? 5'h00 : period_q + 5'h01; // [RULE10]
                end
            end else begin
                half_q <= half_q + 14'h0001;
            end
        end
    end
    assign INTEG_CLK = integ_q;

    // Comparator steers the reference polarity; its high time is counted
    logic pwm_q;
    logic [19:0] width_q;
    logic [17:0] raw_now;
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pwm_q <= 1'b0;
            width_q <= 20'h0_0000;
        end else if (CE && tick_q) begin
            pwm_q <= COMP_IN; // [RULE16]
            if (conv_end) begin
                width_q <= 20'h0_0000;
            end else if (pwm_q) begin
                width_q <= width_q + 20'h0_0001; // [RULE17]
            end
        end
    end
    assign PWM_REF_SEL = pwm_q;
    // Full scale is 600000 counts; dropping two bits keeps it in 18 bits
    assign raw_now = width_q[19:2]; // [RULE10]

    dat_phase_e phase_q;
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            phase_q <= PH_ZERO;
        end else if (conv_end) begin
            unique case (phase_q)
                PH_ZERO: phase_q <= PH_SAMPLE; // [RULE11]
                PH_SAMPLE: phase_q <= PH_REF; // [RULE11]
                PH_REF: phase_q <= PH_ZERO; // [RULE11]
                default: phase_q <= PH_ZERO;
            endcase
        end
    end
    assign MUX_SEL = phase_q;

    logic [17:0] raw_q;
    logic [17:0] zero_q;
    logic signed [18:0] sample_channel_f_q;
    logic signed [18:0] ref_f_q;
    logic signed [19:0] corr;
    logic signed [19:0] step_s;
    logic signed [19:0] step_r;
    assign corr = 20'($signed({2'b00, raw_now})) - 20'($signed({2'b00, zero_q})); // [RULE18]
    assign step_s = (corr - 20'(sample_channel_f_q)) >>> resp_q; // [RULE13]
    assign step_r = (corr - 20'(ref_f_q)) >>> resp_q; // [RULE13]
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            raw_q <= 18'h0_0000;
            zero_q <= 18'h0_0000;
            sample_channel_f_q <= 19'sh0_0000;
            ref_f_q <= 19'sh0_0000;
        end else if (conv_end) begin
            raw_q <= raw_now; // [RULE10]
            unique case (phase_q)
                PH_ZERO: zero_q <= raw_now; // [RULE12]
                PH_SAMPLE: sample_channel_f_q <= sample_channel_f_q + 19'(step_s); // [RULE13]
                PH_REF: ref_f_q <= ref_f_q + 19'(step_r); // [RULE13]
                default: ;
            endcase
        end
    end
    assign RAW_RESULT = raw_q;

    // Readings at or below zero clamp to one count to keep the log finite
    logic [17:0] sample_channel_pos;
    logic [17:0] ref_pos;
    logic signed [13:0] log_diff;
    logic signed [21:0] au_full;
    assign sample_channel_pos = (sample_channel_f_q < 19'sd1) ? 18'h0_0001 : sample_channel_f_q[17:0];
    assign ref_pos = (ref_f_q < 19'sd1) ? 18'h0_0001 : ref_f_q[17:0];
    assign log_diff = $signed({1'b0, log2_q8(ref_pos)}) - $signed({1'b0, log2_q8(sample_channel_pos)});
    assign au_full = 22'(log_diff) * $signed({14'h0000, LOG10_2_Q8});

    logic calc_q;
    logic [15:0] abs_q;
    logic abs_valid_q;
    logic new_flag_q;
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            calc_q <= 1'b0;
            abs_q <= 16'h0000;
            abs_valid_q <= 1'b0;
        end else if (CE) begin
            calc_q <= conv_end && phase_q == PH_REF;
            abs_valid_q <= calc_q;
            if (calc_q) begin
                // Product is Q.16; eight fraction bits are dropped
                abs_q <= 16'(au_full >>> 8); // [RULE13]
            end
        end
    end
    assign ABSORBANCE_VALUE = abs_q;
    assign ABS_VALID = abs_valid_q;

    // A fresh value arriving with the status read stays flagged
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            new_flag_q <= 1'b0;
        end else if (CE && calc_q) begin
            new_flag_q <= 1'b1;
        end else if (rd_stb && addr[3:0] == OFS_STAT) begin
            new_flag_q <= 1'b0;
        end
    end

    logic [7:0] rd_data;
    always_comb begin
        rd_data = RESET_BYTE;
        unique case (addr[3:0])
            OFS_GAIN: rd_data = {4'h0, gain_q};
            OFS_GRAT: rd_data = {4'h0, grat_q};
            OFS_FILT: rd_data = {4'h0, filt_ph_q};
            OFS_BUZZ: rd_data = {7'h00, buzz_q};
            OFS_RESP: rd_data = {5'h00, resp_q};
            OFS_ABS_LO: rd_data = abs_q[7:0];
            OFS_ABS_HI: rd_data = abs_q[15:8];
            OFS_STAT: rd_data = {4'h0, phase_q, new_flag_q};
            default: rd_data = RESET_BYTE;
        endcase
    end
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            AD_OUT <= RESET_BYTE;
        end else if (CE && (RD_N || rd_n_q)) begin
            // Held through a read so a clear-on-read status is not lost
            AD_OUT <= rd_data; // [RULE6]
        end
    end
    assign AD_OE = ~RD_N & ~rd_n_q & per_sel & ~ALE;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    sequence s_ref_done;
        conv_end && phase_q == PH_REF;
    endsequence
    sequence s_calc_step;
        ##1 CE;
    endsequence

    a_tick_spacing: assert property (CE && tick_q |=> !tick_q) // [RULE2]
        else $error("main tick repeated");
    a_cpu_divide: assert property (CE && tick_q |=> CPU_CLK != $past(CPU_CLK)) // [RULE1]
        else $error("cpu clock did not toggle");
    a_dac_divide: assert property (CE && tick_q && div_q[0] |=> DAC_CLK != $past(DAC_CLK)) // [RULE3]
        else $error("dac clock wrong");
    a_uv_reset: assert property (SUPPLY_LOW |-> !SYS_RESET_N ##1 !SYS_RESET_N) // [RULE5]
        else $error("undervoltage reset missing");
    a_por_hold: assert property ($rose(sys_rst_n_q) |-> $past(por_cnt_q) == 23'(POR_CYC - 1)) // [RULE4]
        else $error("reset released early");
    a_ale_latch: assert property (CE && ALE |=> addr_lo_q == $past(AD_IN)) // [RULE6]
        else $error("address not latched");
    a_gain_write: assert property (wr_stb && addr[3:0] == OFS_GAIN |=> GAIN == $past(AD_IN[3:0])) // [RULE9]
        else $error("gain not updated");
    a_buzz_write: assert property (wr_stb && addr[3:0] == OFS_BUZZ |=> BUZZER == $past(AD_IN[0])) // [RULE15]
        else $error("buzzer not updated");
    a_mux_order: assert property (conv_end && phase_q == PH_ZERO |=> phase_q == PH_SAMPLE) // [RULE11]
        else $error("mux order broken");
    a_zero_capture: assert property (conv_end && phase_q == PH_ZERO |=> zero_q == $past(raw_now)) // [RULE12]
        else $error("zero not captured");
    a_abs_follow: assert property (s_ref_done ##0 s_calc_step |=> ABS_VALID) // [RULE13]
        else $error("absorbance not produced");
endmodule
`default_nettype wire

// ===== verification/dat_preamp_model.sv
/*
 Behavioural pre-amplifier, input multiplexer and modulator comparator.
 Assumes MUX_SEL and GAIN come straight from the timing block.
*/
`timescale 1ns/1ps
`default_nettype none
module dat_preamp_model
    import dat_pkg::*;
(
    input wire logic mclk,
    input wire logic [2:0] mux_sel,
    input wire dat_gain_s gain,
    output logic comp_in
);
    logic [3:0] phase_q = 4'h0;
    logic [4:0] level;
    // Duty in sixteenths; grounded input stays small, not zero, to expose offset handling
    always_comb begin
        case (mux_sel)
            PH_ZERO: level = 5'h01;
            PH_SAMPLE: level = 5'h04 + 5'(gain.sample_channel);
            PH_REF: level = 5'h0A + 5'(gain.refr);
            default: level = 5'h00;
        endcase
    end
    always_ff @(posedge mclk) begin
        phase_q <= phase_q + 4'h1;
    end
    assign comp_in = (5'(phase_q) < level);
endmodule
`default_nettype wire

// ===== verification/tb_dat_timing.sv
/*
 Self-checking bench of the acquisition timing block.
 Assumes a reduced power-on count and integration half period.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_dat_timing;
    import dat_pkg::*;
    localparam int POR_SIM = 50;
    localparam int IH = 4;
    localparam int CONV_CYC = CONV_PERIODS * 2 * IH * CLK_MHZ / MAIN_MHZ;
    localparam int LIMIT = 20000;
    logic MCLK, RESET_N, CE, SUPPLY_LOW, COMP_IN, ALE, RD_N, WR_N;
    logic [7:0] ADDR_HI, AD_IN, AD_OUT;
    logic AD_OE, ROM_CS_N, SRAM_CS_N, EEPROM_CS_N, SYS_RESET_N, ADC_TICK;
    logic CPU_CLK, DAC_CLK, IF_CLK, INTEG_CLK, PWM_REF_SEL, BUZZER, ABS_VALID;
    logic [2:0] MUX_SEL;
    dat_gain_s GAIN;
    logic [3:0] GRATING_PHASE, FILTER_PHASE, prev;
    logic [17:0] RAW_RESULT;
    logic [15:0] ABSORBANCE_VALUE;
    int bad_count = 0, n_tests = 0, cyc = 0, ticks = 0;
    int rises[4] = '{0, 0, 0, 0};
    logic [3:0] clks;
    logic pwm_exp = 1'b0;
    logic pwm_chk = 1'b0;
    assign clks = {INTEG_CLK, IF_CLK, DAC_CLK, CPU_CLK};

    dat_timing #(.POR_CYC(POR_SIM), .INTEG_HALF(IH)) dat_timing_i (.MCLK(MCLK),
        .RESET_N(RESET_N), .CE(CE), .SUPPLY_LOW(SUPPLY_LOW), .COMP_IN(COMP_IN),
        .ALE(ALE), .RD_N(RD_N), .WR_N(WR_N), .ADDR_HI(ADDR_HI), .AD_IN(AD_IN),
        .AD_OUT(AD_OUT), .AD_OE(AD_OE), .ROM_CS_N(ROM_CS_N), .SRAM_CS_N(SRAM_CS_N),
        .EEPROM_CS_N(EEPROM_CS_N), .SYS_RESET_N(SYS_RESET_N), .ADC_TICK(ADC_TICK),
        .CPU_CLK(CPU_CLK), .DAC_CLK(DAC_CLK), .IF_CLK(IF_CLK), .INTEG_CLK(INTEG_CLK),
        .PWM_REF_SEL(PWM_REF_SEL), .MUX_SEL(MUX_SEL), .GAIN(GAIN),
        .GRATING_PHASE(GRATING_PHASE), .FILTER_PHASE(FILTER_PHASE), .BUZZER(BUZZER),
        .RAW_RESULT(RAW_RESULT), .ABSORBANCE_VALUE(ABSORBANCE_VALUE),
        .ABS_VALID(ABS_VALID));
    dat_preamp_model dat_preamp_model_i (.mclk(MCLK), .mux_sel(MUX_SEL), .gain(GAIN),
        .comp_in(COMP_IN));

    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end

    // Edge counters for the divided clocks
    always @(posedge MCLK) begin
        prev <= clks;
        for (int i = 0; i < 4; i++) begin
            if (clks[i] === 1'b1 && prev[i] === 1'b0) begin
                rises[i]++;
            end
        end
        // Values read here are still those launched by the previous edge
        if (pwm_chk) begin
            chk(PWM_REF_SEL, pwm_exp);
        end
        pwm_chk = (ADC_TICK === 1'b1);
        pwm_exp = COMP_IN;
        if (ADC_TICK === 1'b1) begin
            ticks++;
        end
        cyc++;
        if (cyc == LIMIT) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_near(input int got, input int exp, input int tol);
        n_tests++;
        if (got < exp - tol || got > exp + tol) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic int exp_cnt(input int mhz);
        return 1000 * mhz / CLK_MHZ;
    endfunction

    function automatic logic [2:0] exp_cs(input logic [15:0] a);
        return ~{a < 16'h8000, a >= 16'h8000 && a < 16'hA000, a >= 16'hA000 && a < 16'hA800};
    endfunction

    function automatic int exp_raw(input int level);
        return (CONV_PERIODS * 2 * IH * level / 16) >> 2;
    endfunction

    task automatic wait_por();
        int n;
        n = 0;
        while (SYS_RESET_N !== 1'b1 && n < 1000) begin
            @(negedge MCLK);
            n++;
        end
        chk_near(n, POR_SIM, 2);
    endtask

    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge MCLK);
        ALE = 1'b1;
        ADDR_HI = a[15:8];
        AD_IN = a[7:0];
        @(negedge MCLK);
        ALE = 1'b0;
        AD_IN = d;
        WR_N = 1'b0;
        repeat (2) @(negedge MCLK);
        WR_N = 1'b1;
    endtask

    // Address byte is replaced by junk during the data phase so a missing latch shows
    task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge MCLK);
        ALE = 1'b1;
        ADDR_HI = a[15:8];
        AD_IN = a[7:0];
        @(negedge MCLK);
        ALE = 1'b0;
        AD_IN = ~a[7:0];
        RD_N = 1'b0;
        repeat (2) @(negedge MCLK);
        chk({ROM_CS_N, SRAM_CS_N, EEPROM_CS_N}, exp_cs(a));
        chk(AD_OE, a >= 16'hC000 && a < 16'hC010);
        d = AD_OUT;
        RD_N = 1'b1;
    endtask

    initial begin
        int r0[4];
        int t0, n, rz, rs, rr, ex;
        logic [7:0] d[4];
        logic [7:0] rd;
        logic [2:0] old;
        logic [15:0] addrs[9];
        {RESET_N, SUPPLY_LOW, ALE, ADDR_HI, AD_IN} = '0;
        {CE, RD_N, WR_N} = 3'b111;
        void'($urandom(32'h0000_eed2));
        repeat (2) @(negedge MCLK);
        RESET_N = 1'b1;
        wait_por();
        SUPPLY_LOW = 1'b1;
        @(negedge MCLK);
        chk(SYS_RESET_N, 1'b0);
        SUPPLY_LOW = 1'b0;
        wait_por();
        r0 = rises;
        t0 = ticks;
        repeat (1000) @(negedge MCLK);
        chk_near(ticks - t0, exp_cnt(MAIN_MHZ), 1);
        chk_near(rises[0] - r0[0], exp_cnt(CPU_MHZ), 1);
        chk_near(rises[1] - r0[1], exp_cnt(DAC_MHZ), 1);
        chk_near(rises[2] - r0[2], exp_cnt(IF_MHZ), 1);
        chk_near(rises[3] - r0[3], exp_cnt(MAIN_MHZ) / (2 * IH), 1);
        // Clock enable low freezes every divider; one edge lets the last rise drain
        CE = 1'b0;
        @(negedge MCLK);
        r0 = rises;
        t0 = ticks;
        repeat (20) @(negedge MCLK);
        chk(ticks - t0, 0);
        chk(rises[0] - r0[0] + rises[1] - r0[1], 0);
        chk(rises[2] - r0[2] + rises[3] - r0[3], 0);
        CE = 1'b1;
        for (int i = 0; i < 4; i++) begin
            d[i] = 8'($urandom);
            bus_wr({12'hC00, 4'(i)}, d[i]);
        end
        chk(GAIN, d[0][3:0]);
        chk(GRATING_PHASE, d[1][3:0]);
        chk(FILTER_PHASE, d[2][3:0]);
        chk(BUZZER, d[3][0]);
        for (int i = 0; i < 4; i++) begin
            bus_rd({12'hC00, 4'(i)}, rd);
            chk(rd, d[i] & ((i == 3) ? 8'h01 : 8'h0F));
        end
        bus_wr(16'hC008, 8'hFF);
        bus_rd(16'hC008, rd);
        chk(rd, 8'h00);
        addrs = '{16'h0000, 16'h7FFF, 16'h8000, 16'h9FFF, 16'hA000, 16'hA7FF,
                  16'hA800, 16'hC00F, 16'($urandom)};
        foreach (addrs[i]) begin
            bus_rd(addrs[i], rd);
        end
        // Shift of zero makes each filtered value the latest reading less the zero reading
        bus_wr({12'hC00, OFS_RESP}, 8'h00);
        {rz, rs, rr} = '0;
        for (int i = 0; i < 8; i++) begin
            old = MUX_SEL;
            n = 0;
            while (MUX_SEL === old && n < 2000) begin
                @(negedge MCLK);
                n++;
            end
            chk(MUX_SEL, {old[1:0], old[2]});
            if (i > 0 && old !== PH_ZERO) begin
                chk_near(n, CONV_CYC, 3);
            end
            if (old === PH_ZERO) begin
                rz = int'(RAW_RESULT);
                chk_near(rz, exp_raw(1), 3);
            end else if (old === PH_SAMPLE) begin
                rs = int'(RAW_RESULT);
                chk_near(rs, exp_raw(4 + d[0][1:0]), 3);
            end else begin
                rr = int'(RAW_RESULT);
                chk_near(rr, exp_raw(10 + d[0][3:2]), 3);
                n = 0;
                while (ABS_VALID !== 1'b1 && n < 5) begin
                    @(negedge MCLK);
                    n++;
                end
                if (i > 3) begin
                    ex = $rtoi($log10(real'(rr - rz) / real'(rs - rz)) * 256.0);
                    chk_near(int'($signed(ABSORBANCE_VALUE)), ex, 8);
                    chk(ABS_VALID, 1'b1);
                    @(negedge MCLK);
                    chk(ABS_VALID, 1'b0);
                    // Result bytes and the status word, whose new flag clears on read
                    bus_rd({12'hC00, OFS_ABS_LO}, rd);
                    chk(rd, ABSORBANCE_VALUE[7:0]);
                    bus_rd({12'hC00, OFS_ABS_HI}, rd);
                    chk(rd, ABSORBANCE_VALUE[15:8]);
                    bus_rd({12'hC00, OFS_STAT}, rd);
                    chk(rd, {4'h0, PH_ZERO, 1'b1});
                    bus_rd({12'hC00, OFS_STAT}, rd);
                    chk(rd, {4'h0, PH_ZERO, 1'b0});
                end
            end
        end
        complete_run();
    end
endmodule
`default_nettype wire
